// ===== include/ddr2_ext_pkg.sv
// Summary of operation
// - Two termination select bits choose off, 50, 75 or 150 ohm.
// - Selected termination applies to every data, strobe and mask lane alike.
// - With termination enabled, the control pin switches it on or off.
// - Control pin honoured only in active, active power-down and precharge power-down.
// - Three-bit field sets posted latency 0 to 6; code 7 is reserved.
// - Each read or write is held the posted latency before internal issue.
// - First read data after posted latency plus column latency.
// - Write data taken one clock before the read latency.
// - Register three bits are all reserved and steer nothing.
// - Mode registers load only by the load command and hold until reloaded.
// - A register reload leaves the memory array untouched.
package ddr2_ext_pkg;

  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [2:0] bank;
    logic [15:0] addr;
  } cmd_bus_t;

  typedef logic [16:0] emr_t;
  typedef enum logic [1:0] {RTT_OFF, RTT_75, RTT_150, RTT_50} rtt_t;
  typedef enum logic [2:0] {
    PS_INIT, PS_IDLE, PS_ACTIVE, PS_ACT_PD_FAST, PS_ACT_PD_SLOW, PS_PRE_PD, PS_SELF_REFRESH
  } pwr_state_t;

  localparam cmd_bus_t CMD_IDLE = '{cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1,
                                    bank: 3'h0, addr: 16'h0000};
  localparam emr_t EMR_RST = 17'h00000;
  localparam logic [1:0] BANK_EMR1 = 2'h1;
  localparam logic [1:0] BANK_EXTENDED_CONFIG_REG_TWO = 2'h2;
  localparam logic [1:0] BANK_EXTENDED_CONFIG_REG_THREE = 2'h3;
  localparam int RTT_LO_BIT = 2;
  localparam int RTT_HI_BIT = 6;
  localparam int AL_LSB = 3;
  localparam int OCD_LSB = 7;
  localparam int FAST_REFRESH_BIT = 7;
  localparam int MODE_TOP_BIT = 12;
  localparam logic [2:0] AL_MAX = 3'h6;
  localparam logic [2:0] CL_MIN = 3'h3;
  localparam logic [2:0] CL_MAX = 3'h7;
  localparam logic [2:0] CL_RST = 3'h3;
  localparam int RL_MAX = 13;
  localparam logic [2:0] OCD_EXIT = 3'h0;
  localparam logic [2:0] OCD_DEFAULT = 3'h7;
  localparam logic [3:0] TERM_ARM_CLKS = 4'h8;
  localparam int TERM_LANES = 12;
  localparam logic [7:0] OFS_EMR1 = 8'h00;
  localparam logic [7:0] OFS_EXTENDED_CONFIG_REG_TWO = 8'h04;
  localparam logic [7:0] OFS_EXTENDED_CONFIG_REG_THREE = 8'h08;
  localparam logic [7:0] OFS_LATENCY = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam int ST_EARLY_TERM = 0;
  localparam int ST_AL_RSVD = 1;
  localparam int ST_RSVD_BITS = 2;
  localparam int ST_OCD_CAL = 3;
  localparam logic [3:0] STATUS_RST = 4'h0;

endpackage

// ===== design/pin_sync2.sv
module pin_sync2 (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Asynchronous level in, synchronised level out
  input wire logic d,
  output logic q
);

  logic meta_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= 1'b0;
      q <= 1'b0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end

endmodule

// ===== design/tap_delay_line.sv
module tap_delay_line #(
  parameter int W = 1,
  parameter int DEPTH = 6,
  parameter int TAP_W = 3
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Strobes in, selected tap out
  input wire logic [W-1:0] d,
  input wire logic [TAP_W-1:0] tap,
  output logic [W-1:0] q
);

  logic [W-1:0] sr_q [DEPTH];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        sr_q[i] <= '0;
      end
    end else begin
      sr_q[0] <= d;
      for (int i = 1; i < DEPTH; i++) begin
        sr_q[i] <= sr_q[i-1];
      end
    end
  end

  // Tap 0 passes straight through; taps beyond the depth give nothing
  always_comb begin
    if (tap == '0) begin
      q = d;
    end else if (int'(tap) <= DEPTH) begin
      q = sr_q[int'(tap) - 1];
    end else begin
      q = '0;
    end
  end

endmodule

// ===== design/ddr2_ext_config.sv
module ddr2_ext_config (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Command and address bus from the controller
  input wire ddr2_ext_pkg::cmd_bus_t cmd,
  input wire logic termination_control_pin,
  // Device power state, same clock
  input wire ddr2_ext_pkg::pwr_state_t pwr_state,
  // Termination
  output ddr2_ext_pkg::rtt_t effective_termination_value,
  output logic [ddr2_ext_pkg::TERM_LANES-1:0] term_lane_en,
  // Latency strobes
  output logic internal_read_issue,
  output logic internal_write_issue,
  output logic read_data_launch,
  output logic write_data_capture,
  // Other mode outputs
  output logic fast_refresh_select_bit,
  output logic [2:0] driver_impedance_calibration
);
  import ddr2_ext_pkg::*;

  cmd_bus_t cmd_q;
  emr_t extended_config_reg_one_q;
  emr_t extended_config_reg_two_q;
  emr_t extended_config_reg_three_q;
  logic [2:0] column_access_latency_q;
  logic [3:0] status_q;
  logic [3:0] arm_cnt_q;
  logic [31:0] prdata_q;
  logic load_config_command;
  logic rd_now;
  logic wr_now;
  logic [2:0] al_code;
  logic [2:0] posted_extra_latency;
  logic [3:0] read_delay_total;
  logic [3:0] write_delay_total;
  logic pin_s;
  logic state_ok;
  logic term_on;
  logic rtt_en_new;
  logic load1;
  logic load2;
  logic load3;
  logic setup;
  logic access;
  logic hit;
  logic cl_ok;
  logic wr_err;
  logic [3:0] status_set;

  // Command registration
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_q <= CMD_IDLE;
    end else begin
      cmd_q <= cmd;
    end
  end

  assign load_config_command = !cmd_q.cs_n && !cmd_q.ras_n && !cmd_q.cas_n && !cmd_q.we_n;
  assign rd_now = !cmd_q.cs_n && cmd_q.ras_n && !cmd_q.cas_n && cmd_q.we_n;
  assign wr_now = !cmd_q.cs_n && cmd_q.ras_n && !cmd_q.cas_n && !cmd_q.we_n;
  assign load1 = load_config_command && (cmd_q.bank[1:0] == BANK_EMR1);
  assign load2 = load_config_command && (cmd_q.bank[1:0] == BANK_EXTENDED_CONFIG_REG_TWO);
  assign load3 = load_config_command && (cmd_q.bank[1:0] == BANK_EXTENDED_CONFIG_REG_THREE);

  // Mode registers: only the load command writes them, nothing touches the array
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      extended_config_reg_one_q <= EMR_RST;
      extended_config_reg_two_q <= EMR_RST;
      extended_config_reg_three_q <= EMR_RST;
    end else begin
      if (load1) begin
        extended_config_reg_one_q <= {cmd_q.bank[2], cmd_q.addr};
      end
      if (load2) begin
        extended_config_reg_two_q <= {cmd_q.bank[2], cmd_q.addr};
      end
      if (load3) begin
        extended_config_reg_three_q <= {cmd_q.bank[2], cmd_q.addr};
      end
    end
  end

  assign fast_refresh_select_bit = extended_config_reg_two_q[FAST_REFRESH_BIT];
  assign driver_impedance_calibration = extended_config_reg_one_q[OCD_LSB +: 3];

  // Termination value
  always_comb begin
    unique case ({extended_config_reg_one_q[RTT_HI_BIT], extended_config_reg_one_q[RTT_LO_BIT]})
      2'h0: effective_termination_value = RTT_OFF;
      2'h1: effective_termination_value = RTT_75;
      2'h2: effective_termination_value = RTT_150;
      2'h3: effective_termination_value = RTT_50;
    endcase
  end

  pin_sync2 u_pin_sync (
    .clk(pclk),
    .rst_n(presetn),
    .d(termination_control_pin),
    .q(pin_s)
  );

  always_comb begin
    unique case (pwr_state)
      PS_ACTIVE, PS_ACT_PD_FAST, PS_ACT_PD_SLOW, PS_PRE_PD: state_ok = 1'b1;
      PS_INIT, PS_IDLE, PS_SELF_REFRESH: state_ok = 1'b0;
      default: state_ok = 1'b0;
    endcase
  end

  assign term_on = (effective_termination_value != RTT_OFF) && pin_s && state_ok;

  genvar gi;
  generate
    for (gi = 0; gi < TERM_LANES; gi++) begin : g_lane
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          term_lane_en[gi] <= 1'b0;
        end else begin
          term_lane_en[gi] <= term_on;
        end
      end
    end
  endgenerate

  // Settling window after a load that turns termination on
  assign rtt_en_new = load1 && (cmd_q.addr[RTT_HI_BIT] || cmd_q.addr[RTT_LO_BIT]);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      arm_cnt_q <= 4'h0;
    end else if (rtt_en_new) begin
      arm_cnt_q <= TERM_ARM_CLKS;
    end else if (arm_cnt_q != 4'h0) begin
      arm_cnt_q <= arm_cnt_q - 4'h1;
    end
  end

  // Posted and total latencies
  assign al_code = extended_config_reg_one_q[AL_LSB +: 3];
  assign posted_extra_latency = (al_code > AL_MAX) ? 3'h0 : al_code;
  assign read_delay_total = {1'b0, posted_extra_latency} + {1'b0, column_access_latency_q};
  assign write_delay_total = read_delay_total - 4'h1;

  tap_delay_line #(.W(2), .DEPTH(6), .TAP_W(3)) u_posted (
    .clk(pclk),
    .rst_n(presetn),
    .d({wr_now, rd_now}),
    .tap(posted_extra_latency),
    .q({internal_write_issue, internal_read_issue})
  );

  tap_delay_line #(.W(1), .DEPTH(RL_MAX), .TAP_W(4)) u_read_lat (
    .clk(pclk),
    .rst_n(presetn),
    .d(rd_now),
    .tap(read_delay_total),
    .q(read_data_launch)
  );

  tap_delay_line #(.W(1), .DEPTH(RL_MAX), .TAP_W(4)) u_write_lat (
    .clk(pclk),
    .rst_n(presetn),
    .d(wr_now),
    .tap(write_delay_total),
    .q(write_data_capture)
  );

  // Sticky misuse flags; a new event beats a clear in the same cycle
  always_comb begin
    status_set = 4'h0;
    status_set[ST_EARLY_TERM] = pin_s && (arm_cnt_q != 4'h0);
    status_set[ST_AL_RSVD] = load1 && (cmd_q.addr[AL_LSB +: 3] > AL_MAX);
    status_set[ST_RSVD_BITS] = (load_config_command && cmd_q.bank[0] | cmd_q.bank[1])
      && (cmd_q.bank[2] || (cmd_q.addr[15:MODE_TOP_BIT+1] != 3'h0)
      || (load2 && ((cmd_q.addr & ~(16'h0001 << FAST_REFRESH_BIT)) != 16'h0000))
      || (load3 && (cmd_q.addr != 16'h0000)));
    status_set[ST_OCD_CAL] = load1 && (cmd_q.addr[OCD_LSB +: 3] != OCD_EXIT)
      && (cmd_q.addr[OCD_LSB +: 3] != OCD_DEFAULT);
  end

  // APB slave, zero wait states
  assign setup = psel && !penable;
  assign access = psel && penable;
  assign pready = 1'b1;
  assign hit = (paddr == OFS_EMR1) || (paddr == OFS_EXTENDED_CONFIG_REG_TWO) || (paddr == OFS_EXTENDED_CONFIG_REG_THREE)
    || (paddr == OFS_LATENCY) || (paddr == OFS_STATUS);
  assign cl_ok = (pwdata[2:0] >= CL_MIN) && (pwdata[2:0] <= CL_MAX);
  assign wr_err = pwrite && ((paddr == OFS_EMR1) || (paddr == OFS_EXTENDED_CONFIG_REG_TWO)
    || (paddr == OFS_EXTENDED_CONFIG_REG_THREE) || ((paddr == OFS_LATENCY) && !cl_ok));
  assign pslverr = access && (!hit || wr_err);
  assign prdata = prdata_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      column_access_latency_q <= CL_RST;
    end else if (access && pwrite && (paddr == OFS_LATENCY) && cl_ok) begin
      column_access_latency_q <= pwdata[2:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_q <= STATUS_RST;
    end else if (access && pwrite && (paddr == OFS_STATUS)) begin
      status_q <= (status_q & ~pwdata[3:0]) | status_set;
    end else begin
      status_q <= status_q | status_set;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h00000000;
    end else if (setup && !pwrite) begin
      unique case (paddr)
        OFS_EMR1: prdata_q <= {15'h0000, extended_config_reg_one_q};
        OFS_EXTENDED_CONFIG_REG_TWO: prdata_q <= {15'h0000, extended_config_reg_two_q};
        OFS_EXTENDED_CONFIG_REG_THREE: prdata_q <= {15'h0000, extended_config_reg_three_q};
        OFS_LATENCY: prdata_q <= {16'h0000, write_delay_total, read_delay_total,
          1'b0, posted_extra_latency, 1'b0, column_access_latency_q};
        OFS_STATUS: prdata_q <= {20'h00000, pin_s, arm_cnt_q, term_lane_en[0],
          effective_termination_value, status_q};
        default: prdata_q <= 32'h00000000;
      endcase
    end
  end

  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_rtt_off_gate: assert property (
    effective_termination_value == RTT_OFF |=> !term_lane_en[0])
    else $error("termination on while select bits are zero");
  a_lane_uniform: assert property (
    term_lane_en == {TERM_LANES{term_lane_en[0]}})
    else $error("termination lanes disagree");
  a_pin_follow: assert property (
    (effective_termination_value != RTT_OFF) && state_ok |=> term_lane_en[0] == $past(pin_s))
    else $error("termination does not follow control pin");
  a_state_gate: assert property (
    (pwr_state == PS_SELF_REFRESH) || (pwr_state == PS_IDLE) |=> !term_lane_en[0])
    else $error("termination on in a state that ignores the pin");
  a_load_capture: assert property (
    load1 |=> extended_config_reg_one_q == {$past(cmd_q.bank[2]), $past(cmd_q.addr)})
    else $error("register one not captured from address");
  a_emr_hold: assert property (
    !load_config_command |=> $stable(extended_config_reg_one_q)
      && $stable(extended_config_reg_two_q))
    else $error("mode register changed without a load");
  a_rtt_decode: assert property (
    load1 && (cmd_q.addr[RTT_HI_BIT] == 1'b1) && (cmd_q.addr[RTT_LO_BIT] == 1'b1)
      |=> effective_termination_value == RTT_50)
    else $error("termination select decode wrong");
  a_al_zero: assert property (
    rd_now && (posted_extra_latency == 3'h0) |-> internal_read_issue)
    else $error("read not issued at once with zero posted latency");
  a_al_six: assert property (
    rd_now && (posted_extra_latency == 3'h6) && !load1 ##1 !load1 [*6]
      |-> internal_read_issue)
    else $error("read not issued six clocks later");
  a_read_lat: assert property (
    rd_now && (read_delay_total == 4'h5) && !load1 && !(access && pwrite)
      ##1 (!load1 && !(access && pwrite)) [*5] |-> read_data_launch)
    else $error("read data not launched at read latency");
  a_write_lat: assert property (
    wr_now && (read_delay_total == 4'h5) ##1 (!load1 && !(access && pwrite)) [*4]
      |-> write_data_capture)
    else $error("write data not captured one clock before read latency");

  c_term_on: cover property (rtt_en_new ##[1:20] term_lane_en[0]);
  c_posted_read: cover property (rd_now && (posted_extra_latency == 3'h6));
  c_early_flag: cover property (status_set[ST_EARLY_TERM]);
  c_self_refresh: cover property (pwr_state == PS_SELF_REFRESH && pin_s);

endmodule

// ===== tb/ddr2_ctl_model.sv
module ddr2_ctl_model (
  // Clock
  input wire logic pclk,
  // Command bus and termination pin
  output ddr2_ext_pkg::cmd_bus_t cmd,
  output logic termination_control_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  import ddr2_ext_pkg::*;

  initial begin
    cmd = CMD_IDLE;
    termination_control_pin = 1'b0;
  end

  // Deselected bus shows the inverse of the last value
  task automatic send(input logic [3:0] op, input logic [2:0] ba, input logic [15:0] a);
    @(posedge pclk);
    cmd <= '{cs_n: op[3], ras_n: op[2], cas_n: op[1], we_n: op[0], bank: ba, addr: a};
    @(posedge pclk);
    cmd <= '{cs_n: 1'b1, ras_n: ~op[2], cas_n: ~op[1], we_n: ~op[0], bank: ~ba, addr: ~a};
  endtask

  task automatic load(input logic [1:0] sel, input logic [15:0] a);
    send(4'h0, {1'b0, sel}, a & 16'h1FFF);
    repeat (4) @(posedge pclk);
  endtask

  task automatic rd();
    send(4'h5, 3'h0, 16'h0000);
  endtask

  task automatic wr();
    send(4'h4, 3'h0, 16'h0000);
  endtask

  // Early asks for the pin too soon after an enabling load
  task automatic term_on(input logic early);
    repeat (early ? 2 : 8) @(posedge pclk);
    termination_control_pin <= 1'b1;
  endtask

  task automatic term_off();
    @(posedge pclk);
    termination_control_pin <= 1'b0;
  endtask
endmodule

// ===== tb/ddr2_ext_mode_odt_latency_tb.sv
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin miscompares++; \
  $display("mismatch t=%0t got=%0h exp=%0h", $time, g, e); end end

module ddr2_ext_mode_odt_latency_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ddr2_ext_pkg::*;

  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, pin, err;
  logic iri, iwi, rdl, wdc, frs;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0] dic;
  logic [TERM_LANES-1:0] lanes;
  cmd_bus_t cmd;
  pwr_state_t pwr_state;
  rtt_t rtt;
  int miscompares, comparisons, cyc, t_c, t_i, t_l, t_w, d0;

  ddr2_ctl_model ctl (.pclk(pclk), .cmd(cmd), .termination_control_pin(pin));

  ddr2_ext_config uut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cmd(cmd), .termination_control_pin(pin), .pwr_state(pwr_state),
    .effective_termination_value(rtt), .term_lane_en(lanes), .internal_read_issue(iri),
    .internal_write_issue(iwi), .read_data_launch(rdl), .write_data_capture(wdc),
    .fast_refresh_select_bit(frs), .driver_impedance_calibration(dic));

  always #20 pclk = ~pclk;

  task report_and_stop();
    if (miscompares == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Strobe times relative to the column command
  always @(posedge pclk) begin
    cyc++;
    if (cmd.cs_n === 1'b0 && cmd.ras_n === 1'b1) t_c = cyc;
    if (iri === 1'b1 || iwi === 1'b1) t_i = cyc;
    if (rdl === 1'b1) t_l = cyc;
    if (wdc === 1'b1) t_w = cyc;
    if (cyc > 6000) begin
      miscompares++;
      report_and_stop();
    end
  end

  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic t_reset();
    apb(OFS_LATENCY, 1'b0, 0);
    `CHK(rd, 32'h0000_2303)
    apb(OFS_EMR1, 1'b0, 0);
    `CHK(rd, 32'h0000_0000)
    `CHK(rtt, RTT_OFF)
    `CHK(lanes, 12'h000)
  endtask

  task automatic t_apb_err();
    apb(8'hFC, 1'b0, 0);
    `CHK({err, rd}, {1'b1, 32'h0})
    apb(OFS_EMR1, 1'b1, 32'hFFFF_FFFF);
    `CHK(err, 1'b1)
    apb(OFS_LATENCY, 1'b1, 32'h2);
    `CHK(err, 1'b1)
    apb(OFS_EMR1, 1'b0, 0);
    `CHK(rd, 32'h0)
    apb(OFS_LATENCY, 1'b0, 0);
    `CHK(rd[2:0], 3'h3)
  endtask

  task automatic t_regs();
    ctl.load(BANK_EMR1, 16'h0380);
    apb(OFS_EMR1, 1'b0, 0);
    `CHK(rd, 32'h0000_0380)
    `CHK(dic, OCD_DEFAULT)
    ctl.load(BANK_EXTENDED_CONFIG_REG_TWO, 16'h0080);
    `CHK(frs, 1'b1)
    apb(OFS_EXTENDED_CONFIG_REG_TWO, 1'b0, 0);
    `CHK(rd, 32'h0000_0080)
    ctl.load(BANK_EXTENDED_CONFIG_REG_THREE, 16'h1FFF);
    apb(OFS_EXTENDED_CONFIG_REG_THREE, 1'b0, 0);
    `CHK(rd, 32'h0000_1FFF)
    `CHK({frs, dic}, 4'hF)
    ctl.load(BANK_EMR1, 16'h0000);
    `CHK(dic, OCD_EXIT)
  endtask

  task automatic t_term();
    for (int c = 1; c < 4; c++) begin
      ctl.load(BANK_EMR1, {9'h0, c[1], 3'h0, c[0], 2'h0});
      `CHK(rtt, rtt_t'(c))
      pwr_state <= PS_ACTIVE;
      ctl.term_on(1'b0);
      repeat (5) @(posedge pclk);
      `CHK(lanes, 12'hFFF)
      for (int s = 0; s < 6; s++) begin
        pwr_state <= pwr_state_t'(s);
        repeat (5) @(posedge pclk);
        `CHK(lanes, {TERM_LANES{s inside {[2:5]}}})
      end
      ctl.term_off();
      repeat (5) @(posedge pclk);
      `CHK(lanes, 12'h000)
    end
    ctl.load(BANK_EMR1, 16'h0000);
    ctl.term_on(1'b0);
    repeat (5) @(posedge pclk);
    `CHK(lanes, 12'h000)
    ctl.term_off();
    ctl.load(BANK_EMR1, 16'h0004);
    ctl.term_on(1'b1);
    repeat (10) @(posedge pclk);
    apb(OFS_STATUS, 1'b0, 0);
    `CHK(rd[ST_EARLY_TERM], 1'b1)
    apb(OFS_STATUS, 1'b1, 32'h1);
    apb(OFS_STATUS, 1'b0, 0);
    `CHK(rd[ST_EARLY_TERM], 1'b0)
    ctl.term_off();
  endtask

  task automatic t_lat();
    int als[3] = '{0, 2, 6};
    int cls[2] = '{3, 7};
    for (int i = 0; i < 3; i++) begin
      for (int j = 0; j < 2; j++) begin
        ctl.load(BANK_EMR1, 16'(als[i] << AL_LSB));
        apb(OFS_LATENCY, 1'b1, 32'(cls[j]));
        apb(OFS_LATENCY, 1'b0, 0);
        `CHK(rd, {16'h0, 4'(als[i] + cls[j] - 1), 4'(als[i] + cls[j]), 1'b0, 3'(als[i]), 1'b0, 3'(cls[j])})
        ctl.rd();
        repeat (20) @(posedge pclk);
        if (i == 0 && j == 0) d0 = t_i - t_c;
        `CHK(t_i - t_c - d0, als[i])
        `CHK(t_l - t_i, cls[j])
        ctl.wr();
        repeat (20) @(posedge pclk);
        `CHK(t_w - t_i, cls[j] - 1)
      end
    end
    ctl.load(BANK_EMR1, 16'h0038);
    apb(OFS_LATENCY, 1'b0, 0);
    `CHK(rd[6:4], 3'h0)
    apb(OFS_STATUS, 1'b0, 0);
    `CHK(rd[ST_AL_RSVD], 1'b1)
  endtask

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    pwr_state = PS_IDLE;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_apb_err();
    t_regs();
    t_term();
    t_lat();
    report_and_stop();
  end
endmodule
